// file: pttp_pkg.sv
package pttp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Field widths and table size
    localparam int POS_W     = 21;
    localparam int SPD_W     = 16;
    localparam int TIME_W    = 15;
    localparam int IDX_W     = 8;
    localparam int TBL_DEPTH = 256;
    localparam int EV_N      = 3;

    ////////////////////////////////////////////////////////////////////////
    // Field limits and codes
    localparam int         POS_MAX       = 999999;
    localparam int         TIME_MAX_MS   = 20000;
    localparam int         AUX_MAX       = 3;
    localparam logic [7:0] LAST_ENTRY    = 8'hFF;
    localparam logic [1:0] AUX_ABS_ONE   = 2'h0;
    localparam logic [1:0] AUX_ABS_CHAIN = 2'h1;
    localparam int         AUX_CHAIN_BIT = 0;
    localparam int         AUX_INCR_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int MS_NS           = 1000000;
    localparam int PTTP_CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int RATED_RPM_DEF   = 3000;
    localparam int PERM_RPM_DEF    = 6000;
    localparam int STEP_DIV_DEF    = 1000;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CFG  = 8'h00;
    localparam logic [7:0] OFS_SEL  = 8'h04;
    localparam logic [7:0] OFS_EIDX = 8'h08;
    localparam logic [7:0] OFS_EPOS = 8'h0C;
    localparam logic [7:0] OFS_ESPD = 8'h10;
    localparam logic [7:0] OFS_EACC = 8'h14;
    localparam logic [7:0] OFS_EDEC = 8'h18;
    localparam logic [7:0] OFS_EDWL = 8'h1C;
    localparam logic [7:0] OFS_EAUX = 8'h20;
    localparam logic [7:0] OFS_ECMT = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] OFS_IST  = 8'h2C;
    localparam logic [7:0] OFS_IMSK = 8'h30;
    localparam logic [7:0] OFS_POS  = 8'h34;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int         SEL_START_BIT = 8;
    localparam int         STAT_BUSY_BIT = 3;
    localparam int         EV_DONE       = 0;
    localparam int         EV_CHAIN      = 1;
    localparam int         EV_RANGE      = 2;
    localparam logic [1:0] EXP_RST       = 2'h0;
    localparam logic [2:0] IMSK_RST      = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LOAD  = 3'h1,
        ST_RUN   = 3'h2,
        ST_REV   = 3'h3,
        ST_DWELL = 3'h4
    } pttp_state_t;

endpackage

// file: pttp_ramp.sv
`timescale 1ns/1ps
module pttp_ramp
    import pttp_pkg::*;
#(
    parameter int CYC_PER_MS = PTTP_CYC_PER_MS,
    parameter int RATED_RPM  = RATED_RPM_DEF
)(
    input  logic              clk,
    input  logic              nrst,
    input  logic [SPD_W-1:0]  tgt,
    input  logic [TIME_W-1:0] acc_ms,
    input  logic [TIME_W-1:0] dec_ms,
    output logic [SPD_W-1:0]  vel_q
);

    // One speed step per cycle at most, so the rate must fit
    if (RATED_RPM < 1 || RATED_RPM > CYC_PER_MS) begin : g_bad
        $error("RATED_RPM out of range");
    end

    logic              up;
    logic              dn;
    logic [TIME_W-1:0] ms;
    logic [31:0]       per;
    logic [31:0]       frac_q;
    logic [31:0]       sum;

    assign up  = tgt > vel_q;
    assign dn  = tgt < vel_q;
    assign ms  = up ? acc_ms : dec_ms;
    assign per = 32'(ms) * 32'(CYC_PER_MS);
    assign sum = frac_q + 32'(RATED_RPM);

    // Error accumulator: rated speed per ms count gives exact slope
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            vel_q  <= '0;
            frac_q <= '0;
        end
        else if (!up && !dn)
            frac_q <= '0;
        else if (ms == '0)
            vel_q <= tgt;
        else if (sum >= per)
        begin
            vel_q  <= up ? vel_q + 16'h0001 : vel_q - 16'h0001;
            frac_q <= sum - per;
        end
        else
            frac_q <= sum;
    end

    acc_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        up && acc_ms == '0 |=> vel_q == $past(tgt))
        else $error("zero accel time did not jump");

    dec_slope_a: assert property (@(posedge clk) disable iff (!nrst)
        dn && dec_ms != '0 |=> vel_q >= $past(vel_q) - 16'h0001)
        else $error("decel faster than one step");

endmodule

// file: pttp_timer.sv
`timescale 1ns/1ps
module pttp_timer
    import pttp_pkg::*;
#(
    parameter int CYC_PER_MS = PTTP_CYC_PER_MS
)(
    input  logic              clk,
    input  logic              nrst,
    input  logic              start,
    input  logic [TIME_W-1:0] ms,
    output logic              done_q
);

    logic [TIME_W-1:0] ms_q;
    logic [31:0]       pre_q;
    logic              run_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ms_q   <= '0;
            pre_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                ms_q  <= ms;
                pre_q <= '0;
                run_q <= ms != '0;
                done_q <= ms == '0;
            end
            else if (run_q && pre_q == 32'(CYC_PER_MS - 1))
            begin
                pre_q <= '0;
                ms_q  <= ms_q - 15'h0001;
                if (ms_q == 15'h0001)
                begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end
            end
            else if (run_q)
                pre_q <= pre_q + 32'h00000001;
        end
    end

endmodule

// file: pttp_core.sv
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Position field takes -999999..999999, scaled by ten to feed exponent in um.
// - Incremental entries add the field to present position; negative runs reverse.
// - Acceleration time 0..20000 ms, standstill to rated speed.
// - Deceleration time 0..20000 ms, rated speed to standstill.
// - With dwell set, finish the move, wait the dwell, then start next.
// - Dwell and aux code apply only to pin or remote-bit selection; here only pin selection uses them, a SEL start runs as aux 0 with no dwell.
// - Aux 0 absolute single entry, aux 1 absolute chained without stop.
// - Aux 2 incremental single entry, aux 3 incremental chained.
// - Aux 0 ignores dwell; aux 1 with zero dwell runs continuously.
// - On a direction change wait for zero command speed first.
// - Entry 255 with aux 1 is an error.
// - Entry number is a binary code on eight selection bits.
module pttp_core
    import pttp_pkg::*;
#(
    parameter int CYC_PER_MS = PTTP_CYC_PER_MS,
    parameter int RATED_RPM  = RATED_RPM_DEF,
    parameter int PERM_RPM   = PERM_RPM_DEF,
    parameter int STEP_DIV   = STEP_DIV_DEF
)(
    input  logic        clk,
    input  logic        nrst,
    input  logic        wb_cyc,
    input  logic        wb_stb,
    input  logic        wb_we,
    input  logic [7:0]  wb_adr,
    input  logic [3:0]  wb_sel,
    input  logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic        wb_ack,
    input  logic [7:0]  sel_in,
    input  logic        start_in,
    output logic [31:0] cmd_pos,
    output logic [15:0] cmd_vel,
    output logic        cmd_rev,
    output logic        busy,
    output logic        irq
);

    if (CYC_PER_MS < 1 || STEP_DIV < 1 || PERM_RPM >= 65536) begin : g_bad
        $error("Bad parameter");
    end

    function automatic logic [31:0] lanes(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[8*b +: 8] = n[8*b +: 8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    pttp_state_t             state_q;
    logic                    ack_q;
    logic [31:0]             rdat_q;
    logic [31:0]             rd_d;
    logic [31:0]             wv;
    logic signed [31:0]      wv_s;
    logic                    req;
    logic                    wr;
    logic [1:0]              exp_q;
    logic [IDX_W-1:0]        eidx_q;
    logic [IDX_W-1:0]        idx_q;
    logic signed [POS_W-1:0] spos_q;
    logic [SPD_W-1:0]        sspd_q;
    logic [TIME_W-1:0]       sacc_q;
    logic [TIME_W-1:0]       sdec_q;
    logic [TIME_W-1:0]       sdwl_q;
    logic [1:0]              saux_q;
    logic [EV_N-1:0]         ist_q;
    logic [EV_N-1:0]         imsk_q;
    logic [EV_N-1:0]         ev;
    logic                    irq_q;
    logic                    busy_q;
    logic                    start_prev_q;
    logic                    from_reg_q;
    logic                    dir_q;
    logic                    ndir_q;
    logic signed [31:0]      pos_q;
    logic signed [31:0]      goal_q;
    logic [31:0]             frac_q;
    logic                    pos_ok;
    logic                    time_ok;
    logic                    bad_wr;

    logic signed [POS_W-1:0] t_pos [TBL_DEPTH];
    logic [SPD_W-1:0]        t_spd [TBL_DEPTH];
    logic [TIME_W-1:0]       t_acc [TBL_DEPTH];
    logic [TIME_W-1:0]       t_dec [TBL_DEPTH];
    logic [TIME_W-1:0]       t_dwl [TBL_DEPTH];
    logic [1:0]              t_aux [TBL_DEPTH];

    logic [1:0]         e_aux;
    logic [TIME_W-1:0]  e_dwl;
    logic [SPD_W-1:0]   e_spd;
    logic signed [31:0] scaled;
    logic signed [31:0] new_goal;
    logic               incr;
    logic               chain;
    logic               load_bad;
    logic               at_goal;
    logic               stopped;
    logic               cont;
    logic               go_dwell;
    logic               pin_go;
    logic               reg_go;
    logic               tmr_done;
    logic [SPD_W-1:0]   vel;
    logic [SPD_W-1:0]   tgt;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one registered ack per request, a cycle after the strobe
    assign req  = wb_cyc & wb_stb & ~ack_q;
    assign wr   = req & wb_we;
    assign wv   = lanes(rd_d, wb_dat_w, wb_sel);
    assign wv_s = signed'(wv);
    assign pos_ok  = wv_s >= -POS_MAX && wv_s <= POS_MAX;
    assign time_ok = wv <= 32'(TIME_MAX_MS);

    always_comb
    begin
        rd_d = '0;
        case (wb_adr)
            OFS_CFG:  rd_d = 32'(exp_q);
            OFS_SEL:  rd_d = 32'(idx_q);
            OFS_EIDX: rd_d = 32'(eidx_q);
            OFS_EPOS: rd_d = 32'(spos_q);
            OFS_ESPD: rd_d = 32'(sspd_q);
            OFS_EACC: rd_d = 32'(sacc_q);
            OFS_EDEC: rd_d = 32'(sdec_q);
            OFS_EDWL: rd_d = 32'(sdwl_q);
            OFS_EAUX: rd_d = 32'(saux_q);
            OFS_STAT: rd_d = {28'h0000000, busy_q, state_q};
            OFS_IST:  rd_d = 32'(ist_q);
            OFS_IMSK: rd_d = 32'(imsk_q);
            OFS_POS:  rd_d = pos_q;
            default:  rd_d = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            ack_q  <= req;
            rdat_q <= req ? rd_d : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Staging registers; out-of-range position, time and aux values are refused
    always_comb
    begin
        bad_wr = 1'b0;
        if (wr)
            case (wb_adr)
                OFS_EPOS: bad_wr = !pos_ok;
                OFS_EACC: bad_wr = !time_ok;
                OFS_EDEC: bad_wr = !time_ok;
                OFS_EDWL: bad_wr = !time_ok;
                OFS_EAUX: bad_wr = wv > 32'(AUX_MAX);
                default:  bad_wr = 1'b0;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            exp_q  <= EXP_RST;
            eidx_q <= '0;
            spos_q <= '0;
            sspd_q <= '0;
            sacc_q <= '0;
            sdec_q <= '0;
            sdwl_q <= '0;
            saux_q <= '0;
            imsk_q <= IMSK_RST;
        end
        else if (wr && !bad_wr)
            case (wb_adr)
                OFS_CFG:  exp_q  <= wv[1:0];
                OFS_EIDX: eidx_q <= wv[IDX_W-1:0];
                OFS_EPOS: spos_q <= wv[POS_W-1:0];
                OFS_ESPD: sspd_q <= wv[SPD_W-1:0];
                OFS_EACC: sacc_q <= wv[TIME_W-1:0];
                OFS_EDEC: sdec_q <= wv[TIME_W-1:0];
                OFS_EDWL: sdwl_q <= wv[TIME_W-1:0];
                OFS_EAUX: saux_q <= wv[1:0];
                OFS_IMSK: imsk_q <= wv[EV_N-1:0];
                default:  ;
            endcase
    end

    // Table memory has no reset; entry 0 does not exist
    always_ff @(posedge clk)
    begin
        if (wr && wb_adr == OFS_ECMT && eidx_q != 8'h00)
        begin
            t_pos[eidx_q] <= spos_q;
            t_spd[eidx_q] <= sspd_q;
            t_acc[eidx_q] <= sacc_q;
            t_dec[eidx_q] <= sdec_q;
            t_dwl[eidx_q] <= sdwl_q;
            t_aux[eidx_q] <= saux_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry decode
    assign e_aux = from_reg_q ? AUX_ABS_ONE : t_aux[idx_q];
    assign e_dwl = from_reg_q ? '0 : t_dwl[idx_q];
    assign e_spd = t_spd[idx_q] > 16'(PERM_RPM) ?
                   16'(PERM_RPM) : t_spd[idx_q];
    assign incr  = e_aux[AUX_INCR_BIT];
    assign chain = e_aux[AUX_CHAIN_BIT];
    assign load_bad = idx_q == LAST_ENTRY && e_aux == AUX_ABS_CHAIN;
    assign at_goal  = pos_q == goal_q;
    assign stopped  = vel == '0;
    assign cont     = chain && e_dwl == '0 && idx_q != LAST_ENTRY;
    assign go_dwell = state_q == ST_RUN && at_goal && !cont && stopped &&
                      chain && e_dwl != '0 && idx_q != LAST_ENTRY;

    always_comb
    begin
        scaled = 32'(t_pos[idx_q]);
        unique case (exp_q)
            2'h0: scaled = 32'(t_pos[idx_q]);
            2'h1: scaled = 32'(t_pos[idx_q]) * 32'sh0000000A;
            2'h2: scaled = 32'(t_pos[idx_q]) * 32'sh00000064;
            2'h3: scaled = 32'(t_pos[idx_q]) * 32'sh000003E8;
        endcase
    end

    assign new_goal = incr ? pos_q + scaled : scaled;
    assign pin_go   = start_in && !start_prev_q && sel_in != 8'h00;
    assign reg_go   = wr && wb_adr == OFS_SEL && wv[SEL_START_BIT] &&
                      wv[IDX_W-1:0] != 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q      <= ST_IDLE;
            idx_q        <= '0;
            from_reg_q   <= 1'b0;
            goal_q       <= '0;
            dir_q        <= 1'b0;
            ndir_q       <= 1'b0;
            start_prev_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= start_in;
            unique case (state_q)
                ST_IDLE:
                    if (reg_go)
                    begin
                        idx_q      <= wv[IDX_W-1:0];
                        from_reg_q <= 1'b1;
                        state_q    <= ST_LOAD;
                    end
                    else if (pin_go)
                    begin
                        idx_q      <= sel_in;
                        from_reg_q <= 1'b0;
                        state_q    <= ST_LOAD;
                    end
                ST_LOAD:
                    if (load_bad)
                        state_q <= ST_IDLE;
                    else
                    begin
                        goal_q <= new_goal;
                        ndir_q <= new_goal < pos_q;
                        if (!stopped && (new_goal < pos_q) != dir_q)
                            state_q <= ST_REV;
                        else
                        begin
                            dir_q   <= new_goal < pos_q;
                            state_q <= ST_RUN;
                        end
                    end
                ST_REV:
                    if (stopped)
                    begin
                        dir_q   <= ndir_q;
                        state_q <= ST_RUN;
                    end
                ST_RUN:
                    if (at_goal && cont)
                    begin
                        idx_q   <= idx_q + 8'h01;
                        state_q <= ST_LOAD;
                    end
                    else if (go_dwell)
                        state_q <= ST_DWELL;
                    else if (at_goal && stopped)
                        state_q <= ST_IDLE;
                ST_DWELL:
                    if (tmr_done)
                    begin
                        idx_q   <= idx_q + 8'h01;
                        state_q <= ST_LOAD;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Speed held across a chained load so the motor does not dip
    always_comb
    begin
        tgt = '0;
        if (state_q == ST_RUN && !at_goal)
            tgt = e_spd;
        else if (state_q == ST_LOAD)
            tgt = vel;
    end

    pttp_ramp #(
        .CYC_PER_MS (CYC_PER_MS),
        .RATED_RPM  (RATED_RPM)
    ) u_ramp (
        .clk    (clk),
        .nrst   (nrst),
        .tgt    (tgt),
        .acc_ms (t_acc[idx_q]),
        .dec_ms (t_dec[idx_q]),
        .vel_q  (vel)
    );

    pttp_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk    (clk),
        .nrst   (nrst),
        .start  (go_dwell),
        .ms     (e_dwl),
        .done_q (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Position integrator; clamps at the goal rather than planning braking
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pos_q  <= '0;
            frac_q <= '0;
        end
        else if (at_goal || stopped)
            frac_q <= '0;
        else if (frac_q + 32'(vel) >= 32'(STEP_DIV))
        begin
            frac_q <= frac_q + 32'(vel) - 32'(STEP_DIV);
            pos_q  <= dir_q ? pos_q - 32'sh00000001
                            : pos_q + 32'sh00000001;
        end
        else
            frac_q <= frac_q + 32'(vel);
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, sticky status (set beats write-one clear), interrupt
    assign ev[EV_DONE]  = state_q == ST_RUN && at_goal && stopped &&
                          !cont && !go_dwell;
    assign ev[EV_CHAIN] = state_q == ST_LOAD && load_bad;
    assign ev[EV_RANGE] = bad_wr;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ist_q  <= '0;
            irq_q  <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            ist_q  <= (ist_q & ~((wr && wb_adr == OFS_IST) ?
                       wv[EV_N-1:0] : 3'h0)) | ev;
            irq_q  <= |(ist_q & imsk_q);
            busy_q <= state_q != ST_IDLE;
        end
    end

    assign wb_ack   = ack_q;
    assign wb_dat_r = rdat_q;
    assign cmd_pos  = pos_q;
    assign cmd_vel  = vel;
    assign cmd_rev  = dir_q;
    assign busy     = busy_q;
    assign irq      = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    pos_range_a: assert property (@(posedge clk) disable iff (!nrst)
        wr && wb_adr == OFS_EPOS && wv_s > POS_MAX
        |=> $stable(spos_q) && ist_q[EV_RANGE])
        else $error("oversize position accepted");

    incr_goal_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_LOAD && !load_bad && incr
        |=> goal_q == $past(pos_q) + $past(scaled))
        else $error("incremental goal wrong");

    abs_goal_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_LOAD && !load_bad && !incr
        |=> goal_q == $past(scaled))
        else $error("absolute goal wrong");

    dwell_still_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_DWELL |-> stopped && at_goal)
        else $error("moving during dwell");

    reg_single_a: assert property (@(posedge clk) disable iff (!nrst)
        from_reg_q && state_q == ST_RUN && at_goal && stopped
        |=> state_q == ST_IDLE)
        else $error("register selection chained");

    chain_cont_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_RUN && at_goal && cont
        |=> state_q == ST_LOAD && idx_q == $past(idx_q) + 8'h01)
        else $error("continuous chain broke");

    rev_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        !$stable(dir_q) |-> $past(vel) == '0)
        else $error("reversed while moving");

    last_err_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_LOAD && load_bad
        |=> state_q == ST_IDLE && ist_q[EV_CHAIN])
        else $error("entry 255 chain not flagged");

    sel_code_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == ST_IDLE && pin_go && !reg_go
        |=> state_q == ST_LOAD && idx_q == $past(sel_in))
        else $error("selection code not taken");

endmodule

// file: pttp_host.sv
`timescale 1ns/1ps
module pttp_host (
    input  logic       clk,
    input  logic       go,
    input  logic [7:0] entry,
    output logic [7:0] sel_in,
    output logic       start_in
);
    logic [2:0] cnt_q;

    initial
    begin
        sel_in = 8'h00;
        start_in = 1'b0;
        cnt_q = 3'h0;
    end

    // Start held for a few cycles; the core acts only on its rising edge while idle
    always @(posedge clk)
    begin
        if (go)
        begin
            sel_in   <= entry;
            start_in <= 1'b1;
            cnt_q    <= 3'h4;
        end
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
        else
            start_in <= 1'b0;
    end
endmodule

// file: point_table_positioning_bench.sv
`timescale 1ns/1ps
module point_table_positioning_bench
    import pttp_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, go = 1'b0, ack, start_in, cmd_rev, busy, irq;
    logic [7:0]  adr = 8'h00, entry = 8'h00, sel_in;
    logic [15:0] cmd_vel;
    logic [31:0] dat = 32'h0, rd, cmd_pos, exp_q[$];
    int          bad_count = 0, num_checks = 0, seed = 19, r;

    initial
        forever #25 clk = ~clk;

    pttp_core #(.CYC_PER_MS(20), .RATED_RPM(10), .STEP_DIV(100)) u_dut (
        .clk(clk), .nrst(nrst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dat), .wb_dat_r(rd),
        .wb_ack(ack), .sel_in(sel_in), .start_in(start_in),
        .cmd_pos(cmd_pos), .cmd_vel(cmd_vel), .cmd_rev(cmd_rev),
        .busy(busy), .irq(irq));

    pttp_host u_host (.clk(clk), .go(go), .entry(entry), .sel_in(sel_in),
        .start_in(start_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        if (!w)
            exp_q.push_back(d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask

    task automatic prog(input logic [7:0] i, input logic [31:0] p, dw, x);
        bus(1'b1, OFS_EIDX, {24'h0, i});
        bus(1'b1, OFS_EPOS, p);
        bus(1'b1, OFS_ESPD, 32'hA);
        bus(1'b1, OFS_EDWL, dw);
        bus(1'b1, OFS_EAUX, x);
        bus(1'b1, OFS_ECMT, 32'h0);
    endtask

    // Waits on busy itself, so slow profiles need no fixed delay
    task automatic idle(input logic bz);
        repeat (4) @(posedge clk);
        chk("busy", {31'h0, bz}, {31'h0, busy});
        while (busy === 1'b1)
            @(posedge clk);
    endtask

    task automatic run(input logic [7:0] e, input logic bz);
        {entry, go} <= {e, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        idle(bz);
    endtask

    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0)
            chk("read data", exp_q.pop_front(), rd);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFS_CFG, 32'h0);
        bus(1'b0, OFS_IMSK, 32'h0);
        bus(1'b0, 8'h3C, 32'h0);
        bus(1'b1, OFS_IMSK, 32'h7);
        bus(1'b1, OFS_EACC, 32'h1);
        bus(1'b1, OFS_EDEC, 32'h1);
        r = $random(seed) % 1000000;
        bus(1'b1, OFS_EPOS, 32'(r));
        bus(1'b1, OFS_EPOS, 32'hF4240);
        bus(1'b0, OFS_EPOS, 32'(r));
        bus(1'b1, OFS_EAUX, 32'h4);
        bus(1'b0, OFS_IST, 32'h4);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_IST, 32'h4);
        prog(8'h01, 32'h6, 32'h2, 32'h1);
        prog(8'h02, 32'hFFFFFFFC, 32'h0, 32'h2);
        prog(8'h03, 32'h9, 32'h0, 32'h1);
        prog(8'hFF, 32'h3, 32'h0, 32'h1);
        run(8'h01, 1'b1);
        chk("position", 32'h2, cmd_pos);
        chk("reverse", 32'h1, {31'h0, cmd_rev});
        chk("speed", 32'h0, {16'h0, cmd_vel});
        bus(1'b0, OFS_IST, 32'h1);
        bus(1'b1, OFS_IST, 32'h1);
        run(8'hFF, 1'b0);
        bus(1'b0, OFS_IST, 32'h2);
        bus(1'b1, OFS_IST, 32'h2);
        bus(1'b1, OFS_SEL, 32'h103);
        idle(1'b1);
        chk("position", 32'h9, cmd_pos);
        chk("reverse", 32'h0, {31'h0, cmd_rev});
        // Zero accel, then a moving chain that must reverse through zero
        bus(1'b1, OFS_EACC, 32'h0);
        prog(8'h05, 32'hB, 32'h0, 32'h3);
        prog(8'h06, 32'hFFFFFFFB, 32'h0, 32'h2);
        run(8'h05, 1'b1);
        chk("position", 32'hF, cmd_pos);
        chk("reverse", 32'h1, {31'h0, cmd_rev});
        test_done;
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        bad_count++;
        test_done;
    end
endmodule
